// [logic/tcc_cfg.svh]
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

// register indexes; byte address is four times the index
`define TCC_IDX_SC0      10'h056
`define TCC_IDX_CH0H     10'h057
`define TCC_IDX_CH0L     10'h058
`define TCC_IDX_SC1      10'h059
`define TCC_IDX_CH1H     10'h05A
`define TCC_IDX_CH1L     10'h05B

// status and control field positions
`define TCC_FLAG_BIT     7
`define TCC_IE_BIT       6
`define TCC_MSB_BIT      5
`define TCC_MSA_BIT      4
`define TCC_ELS_HI_BIT   3
`define TCC_ELS_LO_BIT   2
`define TCC_TOV_BIT      1
`define TCC_MAX_BIT      0

// bus answers
`define TCC_RESP_OKAY    2'h0
`define TCC_RESP_SLVERR  2'h2

`define TCC_ELS_OFF      2'h0
`define TCC_ELS_TOGGLE   2'h1
`define TCC_ELS_CLEAR    2'h2
`define TCC_ELS_SET      2'h3

`endif

// [logic/tcc_pkg.sv]
package tcc_pkg;

	typedef enum logic [1:0] {
		MODE_PRESET   = 2'b00,
		MODE_CAPTURE  = 2'b01,
		MODE_COMPARE  = 2'b10,
		MODE_BUFFERED = 2'b11
	} chan_mode_t;

	typedef struct packed {
		logic             aw_have;
		logic [11:0]      aw_addr;
		logic             w_have;
		logic [7:0]       w_data;
		logic             w_strb0;
		logic             b_valid;
		logic [1:0]       b_resp;
		logic             r_valid;
		logic [7:0]       r_data;
		logic [1:0]       r_resp;
		logic [1:0]       flag;
		logic [1:0]       ie;
		logic             msb0;
		logic [1:0]       msa;
		logic [1:0][1:0]  els;
		logic [1:0]       tov;
		logic [1:0]       max;
		logic [1:0]       max_eff;
		logic [1:0][15:0] val;
		logic [15:0]      cmp0_buf;
		logic [1:0]       cap_lock;
		logic [1:0]       cmp_lock;
		logic [1:0]       clr_armed;
		logic [1:0]       match_prev;
		logic [1:0]       pin_s1;
		logic [1:0]       pin_s2;
		logic [1:0]       pin_prev;
		logic [1:0]       out;
		logic [1:0]       oe;
		logic [1:0]       irq;
	} state_t;

endpackage

// [logic/timer_channel_capture_compare.sv]
`timescale 1ns/1ps
`include "tcc_cfg.svh"

// Behaviour
// RULE1: capture mode sets channel flag on selected active pin edge.
// RULE2: compare mode sets channel flag when counter equals channel value.
// RULE3: flag clears by status read with flag set, then writing zero.
// RULE4: event between that read and the zero write cancels the clear.
// RULE5: writing one to the flag does nothing; reset clears flag.
// RULE6: interrupt enable gates the channel request; reset clears it.
// RULE7: buffered select exists on channel 0 only; channel 1 reads zero.
// RULE8: with edge field nonzero, unbuffered select picks compare over capture.
// RULE9: with edge field zero, unbuffered select presets output: one low, zero high.
// RULE10: software stops and resets counter before changing mode selects.
// RULE11: edge field zero releases pin to port, holds preset state.
// RULE12: capture edges: 01 rising, 10 falling, 11 both.
// RULE13: compare actions: 01 toggle, 10 drive low, 11 drive high.
// RULE14: buffered select forces buffered compare/PWM with same actions.
// RULE15: outside keeps pin stable two bus clocks before capture enable.
// RULE16: toggle-on-overflow toggles compare output each overflow; reset clears.
// RULE17: overflow action beats compare action in the same cycle.
// RULE18: with toggle-on-overflow, full-duty bit forces 100 percent duty.
// RULE19: full-duty change applies from the next PWM period.
// RULE20: value registers hold capture or compare value.
// RULE21: capture mode high byte read blocks captures until low byte read.
// RULE22: compare mode high byte write blocks compares until low byte write.
// RULE23: counter overflow at modulo drives toggle-on-overflow behaviour.
// RULE24: counter halt suppresses captures until cleared.
// RULE25: capture copies counter into value registers with the flag set.
// RULE26: interrupt request is flag and enable both one.
module timer_channel_capture_compare (
	// clock and reset
	input  wire logic        i_ref_clk,
	input  wire logic        i_sys_rst,
	// shared counter
	input  wire logic [15:0] i_counter_value,
	input  wire logic        i_counter_overflow,
	input  wire logic        i_counter_halt,
	// channel pins
	input  wire logic [1:0]  i_channel_pin,
	output logic [1:0]       o_channel_pin,
	output logic [1:0]       o_channel_pin_oe,
	// interrupt requests
	output logic [1:0]       o_channel_irq,
	// axi4-lite write
	input  wire logic [11:0] i_s_axi_awaddr,
	input  wire logic        i_s_axi_awvalid,
	output logic             o_s_axi_awready,
	input  wire logic [31:0] i_s_axi_wdata,
	input  wire logic [3:0]  i_s_axi_wstrb,
	input  wire logic        i_s_axi_wvalid,
	output logic             o_s_axi_wready,
	output logic [1:0]       o_s_axi_bresp,
	output logic             o_s_axi_bvalid,
	input  wire logic        i_s_axi_bready,
	// axi4-lite read
	input  wire logic [11:0] i_s_axi_araddr,
	input  wire logic        i_s_axi_arvalid,
	output logic             o_s_axi_arready,
	output logic [31:0]      o_s_axi_rdata,
	output logic [1:0]       o_s_axi_rresp,
	output logic             o_s_axi_rvalid,
	input  wire logic        i_s_axi_rready
);

	tcc_pkg::state_t q;
	tcc_pkg::state_t d;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [9:0] reg_index(input logic [11:0] addr);
		reg_index = addr[11:2];
	endfunction

	// one decode per register kind, shared by the write and the read path
	function automatic logic is_status(input logic [9:0] idx);
		is_status = (idx == `TCC_IDX_SC0) || (idx == `TCC_IDX_SC1);
	endfunction

	function automatic logic is_value_hi(input logic [9:0] idx);
		is_value_hi = (idx == `TCC_IDX_CH0H) || (idx == `TCC_IDX_CH1H);
	endfunction

	function automatic logic is_value_lo(input logic [9:0] idx);
		is_value_lo = (idx == `TCC_IDX_CH0L) || (idx == `TCC_IDX_CH1L);
	endfunction

	// channel 1 owns the three upper indexes
	function automatic logic chan_of(input logic [9:0] idx);
		chan_of = (idx == `TCC_IDX_SC1) || (idx == `TCC_IDX_CH1H) ||
			(idx == `TCC_IDX_CH1L);
	endfunction

	// rising is wanted by the low field bit, falling by the high one;
	// both inputs come from behind the synchroniser, so no metastable bit reaches it
	function automatic logic edge_seen(
		input logic [1:0] els,
		input logic       now,
		input logic       prev
	);
		edge_seen = (els[0] && now && !prev) || (els[1] && !now && prev); // see RULE12
	endfunction

	// buffered channel compares against the copy taken at the last overflow,
	// so a new value never cuts a running period short
	function automatic logic [15:0] compare_value(
		input tcc_pkg::chan_mode_t md,
		input logic [15:0]         buffered,
		input logic [15:0]         direct
	);
		compare_value = (md == tcc_pkg::MODE_BUFFERED) ? buffered : direct; // see RULE14
	endfunction

	// pin driven only in the compare modes; preset and capture leave it to the port
	function automatic logic drives_pin(input tcc_pkg::chan_mode_t md);
		drives_pin = (md == tcc_pkg::MODE_COMPARE) || (md == tcc_pkg::MODE_BUFFERED);
	endfunction

	// status byte as software reads it
	function automatic logic [7:0] status_byte(
		input logic       flag,
		input logic       ie,
		input logic       msb,
		input logic       msa,
		input logic [1:0] els,
		input logic       tov,
		input logic       max
	);
		status_byte                                   = 8'h00;
		status_byte[`TCC_FLAG_BIT]                    = flag;
		status_byte[`TCC_IE_BIT]                      = ie;
		status_byte[`TCC_MSB_BIT]                     = msb;
		status_byte[`TCC_MSA_BIT]                     = msa;
		status_byte[`TCC_ELS_HI_BIT:`TCC_ELS_LO_BIT]  = els;
		status_byte[`TCC_TOV_BIT]                     = tov;
		status_byte[`TCC_MAX_BIT]                     = max;
	endfunction

	// buffered select wins over everything but a cleared edge field
	function automatic tcc_pkg::chan_mode_t chan_mode(
		input logic       msb,
		input logic       msa,
		input logic [1:0] els
	);
		if (els == `TCC_ELS_OFF) begin
			chan_mode = tcc_pkg::MODE_PRESET; // see RULE11
		end else if (msb) begin
			chan_mode = tcc_pkg::MODE_BUFFERED; // see RULE14
		end else if (msa) begin
			chan_mode = tcc_pkg::MODE_COMPARE; // see RULE8
		end else begin
			chan_mode = tcc_pkg::MODE_CAPTURE; // see RULE8
		end
	endfunction

	function automatic logic compare_level(input logic [1:0] els, input logic cur);
		case (els)
			`TCC_ELS_TOGGLE: compare_level = ~cur; // see RULE13
			`TCC_ELS_CLEAR:  compare_level = 1'b0; // see RULE13
			`TCC_ELS_SET:    compare_level = 1'b1; // see RULE13
			default:         compare_level = cur;
		endcase
	endfunction

	// level that the compare would otherwise end; toggle mode has none, so it holds
	function automatic logic full_level(input logic [1:0] els, input logic cur);
		case (els)
			`TCC_ELS_CLEAR: full_level = 1'b1;
			`TCC_ELS_SET:   full_level = 1'b0;
			default:        full_level = cur;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [1:0]          ev;
		logic [15:0]         cmpv;
		logic                match;
		logic                wr_go;
		logic                rd_go;
		logic [9:0]          widx;
		logic [9:0]          ridx;
		logic                wc;
		logic                rc;
		logic                edge_hit;
		tcc_pkg::chan_mode_t md;
		d        = q;
		ev       = 2'h0;
		cmpv     = 16'h0000;
		match    = 1'b0;
		edge_hit = 1'b0;
		md       = tcc_pkg::MODE_PRESET;
		wr_go    = q.aw_have && q.w_have && !q.b_valid;
		rd_go    = i_s_axi_arvalid && !q.r_valid;
		widx     = reg_index(q.aw_addr);
		ridx     = reg_index(i_s_axi_araddr);
		wc       = chan_of(widx);
		rc       = chan_of(ridx);

		// bus channel capture, either order for address and data
		if (i_s_axi_awvalid && !q.aw_have && !q.b_valid) begin
			d.aw_have = 1'b1;
			d.aw_addr = i_s_axi_awaddr;
		end
		if (i_s_axi_wvalid && !q.w_have && !q.b_valid) begin
			d.w_have  = 1'b1;
			d.w_data  = i_s_axi_wdata[7:0];
			d.w_strb0 = i_s_axi_wstrb[0];
		end
		if (q.b_valid && i_s_axi_bready) begin
			d.b_valid = 1'b0;
		end
		if (q.r_valid && i_s_axi_rready) begin
			d.r_valid = 1'b0;
		end

		// pin synchroniser; only the second stage and later are inspected
		d.pin_s1   = i_channel_pin;
		d.pin_s2   = q.pin_s1;
		d.pin_prev = q.pin_s2;

		// channel events and output drive
		for (int c = 0; c < 2; c++) begin
			md    = chan_mode((c == 0) && q.msb0, q.msa[c], q.els[c]);
			cmpv  = compare_value(md, q.cmp0_buf, q.val[c]);
			match = (i_counter_value == cmpv);
			d.match_prev[c] = match;
			// counter may dwell on one value under the prescaler: flag once per entry
			if (md == tcc_pkg::MODE_CAPTURE) begin
				edge_hit = edge_seen(q.els[c], q.pin_s2[c], q.pin_prev[c]); // see RULE12
				if (edge_hit && !i_counter_halt && !q.cap_lock[c]) begin // see RULE24 see RULE21
					ev[c] = 1'b1; // see RULE1
				end
			end else if (md != tcc_pkg::MODE_PRESET) begin
				if (match && !q.match_prev[c] && !q.cmp_lock[c]) begin // see RULE22
					ev[c] = 1'b1; // see RULE2
				end
			end
			if (md == tcc_pkg::MODE_PRESET) begin
				d.out[c] = ~q.msa[c]; // see RULE9
			end else if (md != tcc_pkg::MODE_CAPTURE) begin
				if (q.tov[c] && q.max_eff[c]) begin
					d.out[c] = full_level(q.els[c], q.out[c]); // see RULE18
				end else if (q.tov[c] && i_counter_overflow) begin
					d.out[c] = ~q.out[c]; // see RULE16 see RULE17 see RULE23
				end else if (ev[c]) begin
					d.out[c] = compare_level(q.els[c], q.out[c]); // see RULE13
				end
			end
			d.oe[c] = drives_pin(md); // see RULE11
			if (i_counter_overflow) begin
				d.max_eff[c] = q.max[c]; // see RULE19
			end
			// in buffered mode the compare copy only moves at a period boundary; otherwise it follows the channel 0 value every cycle
			if (c == 0) begin
				if ((md != tcc_pkg::MODE_BUFFERED) || i_counter_overflow) begin
					d.cmp0_buf = q.val[0]; // see RULE14
				end
			end
		end

		// register write
		if (wr_go) begin
			d.aw_have = 1'b0;
			d.w_have  = 1'b0;
			d.b_valid = 1'b1;
			d.b_resp  = `TCC_RESP_OKAY;
			if (is_status(widx)) begin
				if (q.w_strb0) begin
					if (!q.w_data[`TCC_FLAG_BIT] && q.clr_armed[wc]) begin
						d.flag[wc] = 1'b0; // see RULE3 see RULE5
					end
					d.clr_armed[wc] = 1'b0;
					d.ie[wc]        = q.w_data[`TCC_IE_BIT]; // see RULE6
					if (!wc) begin
						d.msb0 = q.w_data[`TCC_MSB_BIT]; // see RULE7
					end
					d.msa[wc] = q.w_data[`TCC_MSA_BIT];
					d.els[wc] = q.w_data[`TCC_ELS_HI_BIT:`TCC_ELS_LO_BIT];
					d.tov[wc] = q.w_data[`TCC_TOV_BIT];
					d.max[wc] = q.w_data[`TCC_MAX_BIT];
				end
			end else if (is_value_hi(widx)) begin
				if (q.w_strb0) begin
					d.val[wc][15:8] = q.w_data; // see RULE20
					if (chan_mode(!wc && q.msb0, q.msa[wc], q.els[wc]) !=
						tcc_pkg::MODE_CAPTURE) begin
						d.cmp_lock[wc] = 1'b1; // see RULE22
					end
				end
			end else if (is_value_lo(widx)) begin
				if (q.w_strb0) begin
					d.val[wc][7:0] = q.w_data; // see RULE20
					d.cmp_lock[wc] = 1'b0; // see RULE22
				end
			end else begin
				d.b_resp = `TCC_RESP_SLVERR;
			end
		end

		// register read, with its side effects
		if (rd_go) begin
			d.r_valid = 1'b1;
			d.r_resp  = `TCC_RESP_OKAY;
			d.r_data  = 8'h00;
			if (is_status(ridx)) begin
				d.r_data = status_byte(q.flag[rc], q.ie[rc], !rc && q.msb0, q.msa[rc],
					q.els[rc], q.tov[rc], q.max[rc]); // see RULE7
				if (q.flag[rc]) begin
					d.clr_armed[rc] = 1'b1; // see RULE3
				end
			end else if (is_value_hi(ridx)) begin
				d.r_data = q.val[rc][15:8];
				if (chan_mode(!rc && q.msb0, q.msa[rc], q.els[rc]) ==
					tcc_pkg::MODE_CAPTURE) begin
					d.cap_lock[rc] = 1'b1; // see RULE21
				end
			end else if (is_value_lo(ridx)) begin
				d.r_data       = q.val[rc][7:0];
				d.cap_lock[rc] = 1'b0; // see RULE21
			end else begin
				d.r_resp = `TCC_RESP_SLVERR;
			end
		end

		// hardware events last, so a set always beats a clear in the same cycle
		for (int c = 0; c < 2; c++) begin
			md = chan_mode((c == 0) && q.msb0, q.msa[c], q.els[c]);
			if (ev[c]) begin
				d.flag[c]      = 1'b1; // see RULE1 see RULE2
				d.clr_armed[c] = 1'b0; // see RULE4
				if (md == tcc_pkg::MODE_CAPTURE) begin
					d.val[c] = i_counter_value; // see RULE25
				end
			end
		end

		d.irq = d.flag & d.ie; // see RULE26 see RULE6
	end

	////////////////////////////////////////////////////////////////////////////
	// state register

	// value registers are nominally unknown after reset; zero keeps simulation clean
	always_ff @(posedge i_ref_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			q <= '0; // see RULE5 see RULE6 see RULE7 see RULE11 see RULE16
		end else begin
			q <= d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign o_s_axi_awready  = !q.aw_have && !q.b_valid;
	assign o_s_axi_wready   = !q.w_have && !q.b_valid;
	assign o_s_axi_bvalid   = q.b_valid;
	assign o_s_axi_bresp    = q.b_resp;
	assign o_s_axi_arready  = !q.r_valid;
	assign o_s_axi_rvalid   = q.r_valid;
	assign o_s_axi_rresp    = q.r_resp;
	assign o_s_axi_rdata    = {24'h000000, q.r_data};
	assign o_channel_pin    = q.out;
	assign o_channel_pin_oe = q.oe;
	assign o_channel_irq    = q.irq;

endmodule // timer_channel_capture_compare

// [testbench/tcc_asserts.sv]
`timescale 1ns/1ps
module tcc_asserts (
	// clock and reset
	input wire logic        i_ref_clk,
	input wire logic        i_sys_rst,
	// bus
	input wire logic        i_s_axi_awvalid,
	input wire logic        o_s_axi_awready,
	input wire logic        i_s_axi_wvalid,
	input wire logic        o_s_axi_wready,
	input wire logic [1:0]  o_s_axi_bresp,
	input wire logic        o_s_axi_bvalid,
	input wire logic        i_s_axi_bready,
	input wire logic        i_s_axi_arvalid,
	input wire logic        o_s_axi_arready,
	input wire logic [31:0] o_s_axi_rdata,
	input wire logic        o_s_axi_rvalid,
	input wire logic        i_s_axi_rready,
	// channel
	input wire logic [1:0]  o_channel_irq
);
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);
	resp_hold_a: assert property (o_s_axi_bvalid && !i_s_axi_bready |=>
		o_s_axi_bvalid && $stable(o_s_axi_bresp)) else $error("write answer dropped");
	b_drop_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
		else $error("write answer repeated");
	rd_hold_a: assert property (o_s_axi_rvalid && !i_s_axi_rready |=>
		o_s_axi_rvalid && $stable(o_s_axi_rdata)) else $error("read answer changed");
	rd_lat_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
		else $error("read answer late");
	rd_upper_a: assert property (o_s_axi_rvalid |-> o_s_axi_rdata[31:8] == 24'h0)
		else $error("read upper bits set");
	ar_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
		else $error("read taken while busy");
	aw_block_a: assert property (o_s_axi_bvalid |-> !o_s_axi_awready && !o_s_axi_wready)
		else $error("write taken while busy");
	b_lat_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid &&
		o_s_axi_wready |=> ##1 o_s_axi_bvalid) else $error("write answer late");
	cover property (o_s_axi_bvalid && i_s_axi_bready);
	cover property (o_s_axi_rvalid && i_s_axi_rready);
	cover property ($rose(o_channel_irq[1]));
endmodule // tcc_asserts

bind timer_channel_capture_compare tcc_asserts u_chk (
	.i_ref_clk       (i_ref_clk),
	.i_sys_rst       (i_sys_rst),
	.i_s_axi_awvalid (i_s_axi_awvalid),
	.o_s_axi_awready (o_s_axi_awready),
	.i_s_axi_wvalid  (i_s_axi_wvalid),
	.o_s_axi_wready  (o_s_axi_wready),
	.o_s_axi_bresp   (o_s_axi_bresp),
	.o_s_axi_bvalid  (o_s_axi_bvalid),
	.i_s_axi_bready  (i_s_axi_bready),
	.i_s_axi_arvalid (i_s_axi_arvalid),
	.o_s_axi_arready (o_s_axi_arready),
	.o_s_axi_rdata   (o_s_axi_rdata),
	.o_s_axi_rvalid  (o_s_axi_rvalid),
	.i_s_axi_rready  (i_s_axi_rready),
	.o_channel_irq   (o_channel_irq)
);

// [testbench/timer_channel_capture_compare_tb_top.sv]
`timescale 1ns/1ps
module timer_channel_capture_compare_tb_top;
	logic        clk, rst, ovf, halt, awv, wv, bready, arv, rready;
	logic [1:0]  pin, pin_o, oe, irq, bresp, rresp;
	logic [15:0] cnt;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic        awrdy, wrdy, bv, arrdy, rv;
	int          err_total, n_compared, n;

	always #12.5 clk = ~clk;

	timer_channel_capture_compare dut (
		.i_ref_clk(clk), .i_sys_rst(rst), .i_counter_value(cnt),
		.i_counter_overflow(ovf), .i_counter_halt(halt), .i_channel_pin(pin),
		.o_channel_pin(pin_o), .o_channel_pin_oe(oe), .o_channel_irq(irq),
		.i_s_axi_awaddr(awaddr), .i_s_axi_awvalid(awv), .o_s_axi_awready(awrdy),
		.i_s_axi_wdata(wdata), .i_s_axi_wstrb(4'h1), .i_s_axi_wvalid(wv),
		.o_s_axi_wready(wrdy), .o_s_axi_bresp(bresp), .o_s_axi_bvalid(bv),
		.i_s_axi_bready(bready), .i_s_axi_araddr(araddr), .i_s_axi_arvalid(arv),
		.o_s_axi_arready(arrdy), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
		.o_s_axi_rvalid(rv), .i_s_axi_rready(rready));

	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %0t got %h exp %h", $time, g, e);
		end
	endtask

	task automatic summarize;
		if (err_total == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic w(input int k);
		repeat (k) @(posedge clk);
	endtask

	task automatic tmo;
		if (n >= 50) begin
			err_total++;
			summarize;
		end
	endtask

	// master holds each channel until its own ready; readies and answers are
	// taken half a cycle early, where they already stand for the next rising edge
	task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er);
		logic       a;
		logic       b;
		logic       v;
		logic [1:0] r;
		awaddr <= {i, 2'b00};
		wdata <= {24'h0, d};
		awv <= 1'b1;
		wv <= 1'b1;
		n = 0;
		v = 1'b0;
		r = 2'h0;
		do begin
			@(negedge clk);
			a = awrdy;
			b = wrdy;
			v = bv;
			r = bresp;
			@(posedge clk);
			n++;
			if (a) awv <= 1'b0;
			if (b) wv <= 1'b0;
		end while (!v && n < 50);
		tmo;
		chk(r, er);
	endtask

	task automatic rd(input logic [9:0] i, input logic [7:0] e, input logic [1:0] er);
		logic        a;
		logic        v;
		logic [31:0] dat;
		logic [1:0]  r;
		araddr <= {i, 2'b00};
		arv <= 1'b1;
		n = 0;
		v = 1'b0;
		dat = 32'h0;
		r = 2'h0;
		do begin
			@(negedge clk);
			a = arrdy;
			v = rv;
			dat = rdata;
			r = rresp;
			@(posedge clk);
			n++;
			if (a) arv <= 1'b0;
		end while (!v && n < 50);
		tmo;
		chk(dat, {24'h0, e});
		chk(r, er);
	endtask

	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		rd(10'h056, 8'h00, 2'h0);
		chk(oe, 2'b00);
		wr(10'h059, 8'h30, 2'h0);
		rd(10'h059, 8'h10, 2'h0);
		w(3);
		chk(pin_o, 2'b01);
		wr(10'h060, 8'h55, 2'h2);
		rd(10'h060, 8'h00, 2'h2);
	endtask

	task automatic t_cap;
		wr(10'h059, 8'h44, 2'h0);
		pin <= 2'b10;
		w(8);
		chk(irq, 2'b10);
		rd(10'h05A, 8'h12, 2'h0);
		rd(10'h05B, 8'h34, 2'h0);
		rd(10'h059, 8'hC4, 2'h0);
		wr(10'h059, 8'hC4, 2'h0);
		rd(10'h059, 8'hC4, 2'h0);
		wr(10'h059, 8'h44, 2'h0);
		chk(irq, 2'b00);
	endtask

	// falling edge sets flag, then an event spoils the clear
	task automatic t_race;
		wr(10'h059, 8'h4C, 2'h0);
		pin <= 2'b00;
		w(8);
		rd(10'h059, 8'hCC, 2'h0);
		cnt <= 16'h5678;
		pin <= 2'b10;
		w(8);
		wr(10'h059, 8'h4C, 2'h0);
		rd(10'h059, 8'hCC, 2'h0);
	endtask

	task automatic t_lock;
		cnt <= 16'h9ABC;
		rd(10'h05A, 8'h56, 2'h0);
		pin <= 2'b00;
		w(8);
		rd(10'h05B, 8'h78, 2'h0);
		halt <= 1'b1;
		pin <= 2'b10;
		w(8);
		halt <= 1'b0;
		rd(10'h05A, 8'h56, 2'h0);
		rd(10'h05B, 8'h78, 2'h0);
	endtask

	task automatic t_cmp;
		halt <= 1'b1;
		cnt <= 16'h0000;
		wr(10'h056, 8'h10, 2'h0);
		w(2);
		chk(pin_o[0], 1'b0);
		wr(10'h056, 8'h1C, 2'h0);
		halt <= 1'b0;
		wr(10'h057, 8'h00, 2'h0);
		wr(10'h058, 8'h40, 2'h0);
		cnt <= 16'h0040;
		w(3);
		chk({oe[0], pin_o[0]}, 2'b11);
		rd(10'h056, 8'h9C, 2'h0);
		chk(irq, 2'b10);
		wr(10'h056, 8'h18, 2'h0);
		cnt <= 16'h0000;
		wr(10'h057, 8'h00, 2'h0);
		cnt <= 16'h0040;
		w(3);
		chk(pin_o[0], 1'b1);
		wr(10'h058, 8'h40, 2'h0);
		cnt <= 16'h0000;
		w(2);
		cnt <= 16'h0040;
		w(3);
		chk(pin_o[0], 1'b0);
	endtask

	// overflow beats a set-on-compare in the same cycle
	task automatic t_tov;
		cnt <= 16'h0001;
		wr(10'h056, 8'h16, 2'h0);
		ovf <= 1'b1;
		w(1);
		ovf <= 1'b0;
		w(2);
		chk(pin_o[0], 1'b1);
		wr(10'h056, 8'h1E, 2'h0);
		cnt <= 16'h0040;
		ovf <= 1'b1;
		w(1);
		ovf <= 1'b0;
		w(2);
		chk(pin_o[0], 1'b0);
	endtask

	// full duty starts and ends only at the overflow after the write
	task automatic t_full;
		wr(10'h056, 8'h1B, 2'h0);
		ovf <= 1'b1;
		w(1);
		ovf <= 1'b0;
		cnt <= 16'h0000;
		w(2);
		cnt <= 16'h0040;
		w(3);
		chk(pin_o[0], 1'b1);
		wr(10'h056, 8'h1A, 2'h0);
		cnt <= 16'h0000;
		w(2);
		cnt <= 16'h0040;
		w(3);
		chk(pin_o[0], 1'b1);
		ovf <= 1'b1;
		w(1);
		ovf <= 1'b0;
		cnt <= 16'h0000;
		w(2);
		cnt <= 16'h0040;
		w(3);
		chk(pin_o[0], 1'b0);
	endtask

	// buffered compare takes a new value only at the next overflow
	task automatic t_buf;
		wr(10'h056, 8'h2C, 2'h0);
		rd(10'h056, 8'hAC, 2'h0);
		wr(10'h057, 8'h00, 2'h0);
		wr(10'h058, 8'h80, 2'h0);
		cnt <= 16'h0080;
		w(3);
		chk({oe[0], pin_o[0]}, 2'b10);
		ovf <= 1'b1;
		w(1);
		ovf <= 1'b0;
		w(3);
		chk(pin_o[0], 1'b1);
	endtask

	////////////////////////////////////////////////////////////////
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		{ovf, halt, awv, wv, arv} = 5'h00;
		// answers are always accepted, so ready never toggles between transfers
		{bready, rready} = 2'h3;
		pin = 2'b00;
		cnt = 16'h1234;
		{awaddr, araddr, wdata} = 56'h0;
		err_total = 0;
		n_compared = 0;
		w(2);
		rst <= 1'b0;
		t_reset;
		t_cap;
		t_race;
		t_lock;
		t_cmp;
		t_tov;
		t_full;
		t_buf;
		summarize;
	end
endmodule // timer_channel_capture_compare_tb_top
